/* hdl/cct_pkg.sv */
package cct_pkg;

	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;

	// ------------------------------------------------------------
	// Address setup counts, in host clock cycles
	// ------------------------------------------------------------
	localparam logic [4:0] SETUP_IO       = 5'h03;
	localparam logic [4:0] SETUP_MEM_UWS0 = 5'h02;
	localparam logic [4:0] SETUP_MEM_UWS1 = 5'h04;

	// ------------------------------------------------------------
	// Command active counts, 8-bit accesses
	// ------------------------------------------------------------
	localparam logic [4:0] ACT8_NOWAIT = 5'h13;
	localparam logic [4:0] ACT8_WAIT   = 5'h17;
	localparam logic [4:0] ACT8_ZWS    = 5'h07;

	// ------------------------------------------------------------
	// Command active counts, 16-bit accesses
	// ------------------------------------------------------------
	localparam logic [4:0] ACT16_IO_NOWAIT = 5'h07;
	localparam logic [4:0] ACT16_IO_WAIT   = 5'h0B;
	localparam logic [4:0] ACT16_MEM_WS0   = 5'h09;
	localparam logic [4:0] ACT16_MEM_WS1   = 5'h0D;
	localparam logic [4:0] ACT16_MEM_WS2   = 5'h11;
	localparam logic [4:0] ACT16_MEM_WS3   = 5'h17;
	localparam logic [4:0] ACT16_MEM_ZWS   = 5'h05;

	// ------------------------------------------------------------
	// Address hold counts
	// ------------------------------------------------------------
	localparam logic [4:0] HOLD_IO       = 5'h02;
	localparam logic [4:0] HOLD_MEM_UWS0 = 5'h02;
	localparam logic [4:0] HOLD_MEM_UWS1 = 5'h03;

	// ------------------------------------------------------------
	// Cycle sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_ACTIVE,
		ST_HOLD,
		ST_DONE
	} cct_state_t;

endpackage

/* hdl/cct_count_sel.sv */
`timescale 1ns/100ps
module cct_count_sel
	import cct_pkg::*;
(
	// Cycle attributes
	input  wire logic       is_io,
	input  wire logic       is_16bit,
	input  wire logic [1:0] wait_state_select,
	input  wire logic       zero_wait,
	// Selected counts
	output logic      [4:0] setup_cnt,
	output logic      [4:0] active_cnt,
	output logic      [4:0] hold_cnt
);

	logic upper_wait_select;
	logic any_wait;

	// Upper bit lengthens memory setup and hold
	assign upper_wait_select = wait_state_select[1];
	// I/O uses only the low bit of the wait setting
	assign any_wait = is_io ? wait_state_select[0] : (wait_state_select != 2'h0);

	// Setup and hold lookup
	always_comb begin
		if (is_io) begin
			setup_cnt = SETUP_IO; // RL3
			hold_cnt  = HOLD_IO; // RL6
		end else if (upper_wait_select) begin
			setup_cnt = SETUP_MEM_UWS1; // RL3
			hold_cnt  = HOLD_MEM_UWS1; // RL6
		end else begin
			setup_cnt = SETUP_MEM_UWS0; // RL3
			hold_cnt  = HOLD_MEM_UWS0; // RL6
		end
	end

	// Command active lookup; any wait state overrides zero-wait
	always_comb begin
		if (!is_16bit) begin
			if (any_wait)
				active_cnt = ACT8_WAIT; // RL4
			else if (zero_wait)
				active_cnt = ACT8_ZWS; // RL4
			else
				active_cnt = ACT8_NOWAIT; // RL4
		end else if (is_io) begin
			// Zero-wait has no meaning for 16-bit I/O
			active_cnt = any_wait ? ACT16_IO_WAIT : ACT16_IO_NOWAIT; // RL5
		end else begin
			unique case (wait_state_select)
				2'h0: active_cnt = zero_wait ? ACT16_MEM_ZWS : ACT16_MEM_WS0; // RL5
				2'h1: active_cnt = ACT16_MEM_WS1; // RL5
				2'h2: active_cnt = ACT16_MEM_WS2; // RL5
				2'h3: active_cnt = ACT16_MEM_WS3; // RL5
			endcase
		end
	end

endmodule

/* hdl/cct_cycle_gen.sv */
`timescale 1ns/100ps
// What this block does
// RL1: All setup, active and hold times are counted in host clock cycles.
// RL2: Counts come from the window's wait-state settings.
// RL3: Address setup: I/O 3, memory 2 or 4 by upper wait select.
// RL4: 8-bit command: 19 plain, 23 with wait, 7 zero-wait.
// RL5: 16-bit: I/O 7 or 11; memory 9/13/17/23, zero-wait 5.
// RL6: Address hold: I/O 2, memory 2 or 3 by upper wait select.
// RL7: Counts never undercut the legacy timing, yet stay closest to it.
// RL8: Card wait held asserted stretches the command until released.
// RL9: Strict order: address, setup, command, release, hold, then address change.
module cct_cycle_gen
	import cct_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Request from the host target path
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_io,
	input  wire logic        req_16bit,
	input  wire logic        req_write,
	input  wire logic [25:0] req_addr,
	input  wire logic [15:0] req_wdata,
	input  wire logic [1:0]  wait_state_select,
	input  wire logic        zero_wait,
	// Completion
	output logic             done,
	output logic [15:0]      rdata,
	// Card pins
	output logic [25:0]      card_addr,
	output logic             card_addr_valid,
	output logic             card_oe_n,
	output logic             card_we_n,
	output logic             card_iord_n,
	output logic             card_iowr_n,
	output logic [15:0]      card_wdata,
	output logic             card_data_oe,
	input  wire logic [15:0] card_rdata,
	input  wire logic        card_wait_n
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	cct_state_t  state_q;
	logic [4:0]  cnt_q;
	logic        io_q;
	logic        write_q;
	logic [4:0]  active_q;
	logic [4:0]  hold_q;
	logic [25:0] addr_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic        cmd_q;
	logic        wait_meta_q;
	logic        wait_sync_q;
	logic [15:0] data_sync_q;
	logic        capture_q;
	// Lookup results, read only at the take edge; cnt_end marks a phase's last count
	logic [4:0]  setup_sel;
	logic [4:0]  active_sel;
	logic [4:0]  hold_sel;
	logic        cnt_end;

	// ------------------------------------------------------------
	// Count selection from the window settings
	// ------------------------------------------------------------
	cct_count_sel u_sel (
		.is_io             (req_io),
		.is_16bit          (req_16bit),
		.wait_state_select (wait_state_select),
		.zero_wait         (zero_wait),
		.setup_cnt         (setup_sel),
		.active_cnt        (active_sel),
		.hold_cnt          (hold_sel)
	); // RL2 RL7

	// Card wait is asynchronous to the host clock
	// Two stages cost two cycles of lag; wait only stretches, so that costs time, not safety
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_meta_q <= 1'b0;
			wait_sync_q <= 1'b0;
		end else begin
			wait_meta_q <= ~card_wait_n;
			wait_sync_q <= wait_meta_q;
		end
	end

	// Last count of a phase; ready only in idle, so one card cycle at a time
	assign cnt_end   = (cnt_q == 5'h01);
	assign req_ready = (state_q == ST_IDLE);

	// ------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------
	// Counts are plain host clock cycles, no other timebase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			cnt_q   <= 5'h00;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (req_valid) begin
						state_q <= ST_SETUP; // RL9
						cnt_q   <= setup_sel; // RL1 RL3
					end
				end
				ST_SETUP: begin
					if (cnt_end) begin
						state_q <= ST_ACTIVE; // RL9
						cnt_q   <= active_q; // RL4 RL5
					end else begin
						cnt_q <= cnt_q - 5'h01;
					end
				end
				ST_ACTIVE: begin
					// Wait only stretches; it never shortens the minimum
					if (cnt_end && !wait_sync_q) begin
						state_q <= ST_HOLD; // RL8 RL9
						cnt_q   <= hold_q; // RL6
					end else if (!cnt_end) begin
						cnt_q <= cnt_q - 5'h01;
					end
				end
				ST_HOLD: begin
					// Address stays put until the hold count runs out
					if (cnt_end)
						state_q <= ST_DONE; // RL9
					else
						cnt_q <= cnt_q - 5'h01;
				end
				ST_DONE: begin
					// Done stands one cycle, then ready returns
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Request capture; counts frozen for the whole cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			io_q     <= 1'b0;
			write_q  <= 1'b0;
			active_q <= 5'h00;
			hold_q   <= 5'h00;
			addr_q   <= 26'h0000000;
			wdata_q  <= 16'h0000;
		end else if (state_q == ST_IDLE && req_valid) begin
			io_q     <= req_io;
			write_q  <= req_write;
			active_q <= active_sel; // RL2
			hold_q   <= hold_sel; // RL2
			addr_q   <= req_addr; // RL9
			wdata_q  <= req_wdata;
		end
	end

	// Command strobe, registered so it is glitch free on the pins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cmd_q <= 1'b0;
		else if (state_q == ST_SETUP && cnt_end)
			cmd_q <= 1'b1; // RL9
		else if (state_q == ST_ACTIVE && cnt_end && !wait_sync_q)
			cmd_q <= 1'b0; // RL8
	end

	// ------------------------------------------------------------
	// Card read data capture
	// ------------------------------------------------------------
	// Data pins land in a first stage that nothing but the second stage reads
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			data_sync_q <= 16'h0000;
		else
			data_sync_q <= card_rdata;
	end

	// Marks the cycle after the read strobe's trailing edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			capture_q <= 1'b0;
		else
			capture_q <= (state_q == ST_ACTIVE) && cnt_end && !wait_sync_q && !write_q;
	end

	// Trailing-edge sample moves on a cycle later; the hold phase hides the delay
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rdata_q <= 16'h0000;
		else if (capture_q)
			rdata_q <= data_sync_q; // RL9
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Address, frozen from the take edge to the end of hold
	assign card_addr       = addr_q;
	assign card_addr_valid = (state_q == ST_SETUP) || (state_q == ST_ACTIVE) ||
	                         (state_q == ST_HOLD);

	// Strobes; space and direction freeze before the command rises, so no glitch
	assign card_oe_n       = ~(cmd_q && !io_q && !write_q);
	assign card_we_n       = ~(cmd_q && !io_q && write_q);
	assign card_iord_n     = ~(cmd_q && io_q && !write_q);
	assign card_iowr_n     = ~(cmd_q && io_q && write_q);

	// Write data from the captured request
	assign card_wdata      = wdata_q;
	// Write data spans the whole address window for margin
	assign card_data_oe    = write_q && card_addr_valid;

	// Completion
	assign done            = (state_q == ST_DONE);
	assign rdata           = rdata_q;

endmodule

/* testbench/cct_card_model.sv */
`timescale 1ns/100ps
// Card side: read data while selected, wait held for wait_len cycles of each command
module cct_card_model
	import cct_pkg::*;
#(
	parameter logic [15:0] PAT = 16'h5A3C
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Strobes and stretch length
	input  wire logic        card_oe_n,
	input  wire logic        card_we_n,
	input  wire logic        card_iord_n,
	input  wire logic        card_iowr_n,
	input  wire logic [4:0]  wait_len,
	input  wire logic [15:0] card_addr_lo,
	// Card answers
	output logic      [15:0] card_rdata,
	output logic             card_wait_n
);
	logic [4:0] cnt_q;
	wire        cmd = !(card_oe_n & card_we_n & card_iord_n & card_iowr_n);

	// Cycles into the command, saturating
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt_q <= 5'h00;
		else
			cnt_q <= cmd ? cnt_q + {4'h0, cnt_q != 5'h1F} : 5'h00;
	end
	assign card_wait_n = !(cmd && cnt_q < wait_len);

	// Released bus toggles so a stale value never passes; read data follows the address
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			card_rdata <= 16'h0000;
		else if (!card_oe_n || !card_iord_n)
			card_rdata <= PAT ^ card_addr_lo;
		else
			card_rdata <= ~card_rdata;
	end
endmodule

/* testbench/cct_chk.sv */
`timescale 1ns/100ps
module cct_chk (
	// Watched ports
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        req_ready,
	input wire logic        done,
	input wire logic        card_addr_valid,
	input wire logic [25:0] card_addr,
	input wire logic        card_oe_n,
	input wire logic        card_we_n,
	input wire logic        card_iord_n,
	input wire logic        card_iowr_n,
	input wire logic        card_wait_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Any command strobe low
	wire cmd = !(card_oe_n & card_we_n & card_iord_n & card_iowr_n);

	sequence s_stretch;
		(cmd && !card_wait_n)[*4];
	endsequence

	AST_ONE_STROBE: assert property ($onehot0(~{card_oe_n, card_we_n, card_iord_n, card_iowr_n}))
		else $error("two strobes low");
	AST_CMD_IN_ADDR: assert property (cmd |-> card_addr_valid)
		else $error("strobe outside address window");
	AST_ADDR_STABLE: assert property (card_addr_valid && $past(card_addr_valid) |-> $stable(card_addr))
		else $error("address moved");
	AST_SETUP_MIN: assert property ($rose(card_addr_valid) |-> !cmd [*2])
		else $error("setup too short");
	AST_ACTIVE_MIN: assert property ($rose(cmd) |-> cmd [*5])
		else $error("command too short");
	AST_HOLD_MIN: assert property ($fell(cmd) |-> card_addr_valid [*2])
		else $error("hold too short");
	AST_DONE_END: assert property ($fell(card_addr_valid) |-> done)
		else $error("done not at cycle end");
	AST_IDLE: assert property (req_ready |-> !card_addr_valid && !cmd)
		else $error("ready while busy");
	AST_WAIT: assert property (s_stretch |=> cmd)
		else $error("wait ignored");
endmodule

bind cct_cycle_gen cct_chk u_chk (.clk, .nrst, .req_ready, .done, .card_addr_valid, .card_addr,
	.card_oe_n, .card_we_n, .card_iord_n, .card_iowr_n, .card_wait_n);

/* testbench/card_cycle_timing_gen_tb.sv */
`timescale 1ns/100ps
module card_cycle_timing_gen_tb;
	logic        clk, nrst, req_valid, req_ready, req_io, req_16bit, req_write, zero_wait, done;
	logic        card_addr_valid, card_oe_n, card_we_n, card_iord_n, card_iowr_n, card_wait_n;
	logic        card_data_oe;
	logic [1:0]  wait_state_select;
	logic [4:0]  wait_len;
	logic [25:0] req_addr, card_addr;
	logic [15:0] req_wdata, rdata, card_wdata, card_rdata;
	int          miscompares, samples_checked;

	cct_cycle_gen uut (.clk, .nrst, .req_valid, .req_ready, .req_io, .req_16bit, .req_write,
		.req_addr, .req_wdata, .wait_state_select, .zero_wait, .done, .rdata, .card_addr,
		.card_addr_valid, .card_oe_n, .card_we_n, .card_iord_n, .card_iowr_n, .card_wdata,
		.card_data_oe, .card_rdata, .card_wait_n);
	cct_card_model card (.clk, .nrst, .card_oe_n, .card_we_n, .card_iord_n, .card_iowr_n,
		.wait_len, .card_addr_lo(card_addr[15:0]), .card_rdata, .card_wait_n);

	task end_sim;
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One card cycle: measure setup, active and hold at the pins
	task cyc(input logic io, b16, wr, input logic [1:0] ws, input logic zw,
		input logic [4:0] wt, input logic [15:0] es, ea, eh);
		logic [15:0] s, a, h;
		logic [3:0]  km, ek;
		logic        fin;
		int          n;
		s = 16'h0000;
		a = 16'h0000;
		h = 16'h0000;
		km = 4'h0;
		fin = 1'b0;
		ek = {!io && !wr, !io && wr, io && !wr, io && wr};
		// A fresh address and data word per cycle, so stale values cannot pass
		req_addr = {req_addr[24:0], req_addr[25]};
		req_wdata = {req_wdata[14:0], req_wdata[15]};
		{req_io, req_16bit, req_write, wait_state_select, zero_wait} = {io, b16, wr, ws, zw};
		wait_len = wt;
		req_valid = 1'b1;
		// The last cycle's done may still stand here, so judge only after an edge
		for (n = 0; n < 200 && !fin; n++) begin
			@(posedge clk);
			#1;
			fin = done;
			if (card_addr_valid) begin
				req_valid = 1'b0;
				km = ~{card_oe_n, card_we_n, card_iord_n, card_iowr_n};
				chk("data_oe", {15'h0, wr}, {15'h0, card_data_oe});
				if (km != 4'h0) begin
					a++;
					chk("strobe", {12'h0, ek}, {12'h0, km});
					chk("addr_lo", req_addr[15:0], card_addr[15:0]);
					chk("addr_hi", {6'h0, req_addr[25:16]}, {6'h0, card_addr[25:16]});
					if (wr) chk("data_o", req_wdata, card_wdata);
				end else if (a == 0)
					s++;
				else
					h++;
			end
		end
		if (!fin) begin
			miscompares++;
			end_sim();
		end else begin
			chk("setup", es, s);
			chk("hold", eh, h);
			if (wt != 0) chk("stretch", 16'(wt) + 16'h0003, a);
			else chk("active", ea, a);
			if (!wr) chk("rdata", 16'h5A3C ^ req_addr[15:0], rdata);
		end
	endtask

	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	// Main sequence: every memory wait setting and I/O wait settings 0 and 1, on both widths
	initial begin
		{nrst, req_valid, req_io, req_16bit, req_write, zero_wait} = 6'h00;
		{wait_state_select, wait_len, miscompares, samples_checked} = '0;
		req_addr = 26'h2A5A5C3;
		req_wdata = 16'hC3A5;
		repeat (4) @(posedge clk);
		#1 nrst = 1'b1;
		cyc(1, 0, 0, 2'h0, 0, 0, 3, 19, 2);
		cyc(1, 0, 1, 2'h1, 0, 0, 3, 23, 2);
		cyc(1, 0, 0, 2'h0, 1, 0, 3, 7, 2);
		cyc(0, 0, 1, 2'h0, 0, 0, 2, 19, 2);
		cyc(0, 0, 0, 2'h2, 1, 0, 4, 23, 3);
		cyc(0, 0, 0, 2'h0, 1, 0, 2, 7, 2);
		cyc(0, 0, 0, 2'h1, 1, 0, 2, 23, 2);
		cyc(0, 0, 1, 2'h3, 0, 0, 4, 23, 3);
		cyc(1, 1, 1, 2'h0, 0, 0, 3, 7, 2);
		cyc(1, 1, 0, 2'h1, 0, 0, 3, 11, 2);
		cyc(1, 1, 0, 2'h0, 1, 0, 3, 7, 2);
		cyc(0, 1, 0, 2'h0, 0, 0, 2, 9, 2);
		cyc(0, 1, 1, 2'h1, 0, 0, 2, 13, 2);
		cyc(0, 1, 0, 2'h2, 1, 0, 4, 17, 3);
		cyc(0, 1, 1, 2'h3, 0, 0, 4, 23, 3);
		cyc(0, 1, 0, 2'h0, 1, 0, 2, 5, 2);
		cyc(0, 1, 0, 2'h0, 1, 12, 2, 0, 2);
		cyc(1, 0, 1, 2'h0, 0, 25, 3, 0, 2);
		end_sim();
	end
endmodule
